/* rtl/tfp_timer.sv */
// 16-bit timer waveform unit: fast pwm and phase correct pwm, three channels
// assumes timer_tick is a one-pclk strobe from a prescaler, inputs synchronous to pclk
module tfp_timer
  import tfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic [2:0] port_data,
  output logic [2:0] compare_pin_out,
  output logic [2:0] compare_pin_oe
);

  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [15:0] counter_value;
    logic down;
    logic [3:0] waveform_mode_select;
    logic [2:0][1:0] compare_output_action;
    logic [2:0] output_pin_direction;
    logic [2:0][15:0] compare_value;
    logic [2:0][15:0] cmp_buf;
    logic [15:0] capture_top_value;
    logic [2:0] compare_output;
    logic overflow_flag;
    logic capture_match_flag;
    logic [2:0] compare_match_flag;
    logic [31:0] rdata;
  } tfp_state_s;

  tfp_state_s s_q;
  tfp_state_s s_d;

  function automatic logic is_fast(input logic [3:0] m);
    return m == TFP_FAST_8 || m == TFP_FAST_9 || m == TFP_FAST_10 || m == TFP_FAST_CAP || m == TFP_FAST_CMPA;
  endfunction

  function automatic logic is_pc(input logic [3:0] m);
    return m == TFP_PC_8 || m == TFP_PC_9 || m == TFP_PC_10 || m == TFP_PC_CAP || m == TFP_PC_CMPA;
  endfunction

  // fixed resolutions double as mask and top
  function automatic logic [15:0] res_mask(input logic [3:0] m);
    if (m == TFP_PC_8 || m == TFP_FAST_8) begin
      return TFP_TOP_8;
    end else if (m == TFP_PC_9 || m == TFP_FAST_9) begin
      return TFP_TOP_9;
    end else if (m == TFP_PC_10 || m == TFP_FAST_10) begin
      return TFP_TOP_10;
    end
    return TFP_FULL;
  endfunction

  logic fast;
  logic pc;
  logic top_cap;
  logic top_cmpa;
  logic at_top;
  logic wr;
  logic [15:0] top;
  logic [15:0] mask;
  logic [2:0] match;
  logic [2:0] cmp_set;
  logic ovf_set;
  logic cap_set;
  logic [4:0] clr;
  logic eff_up;

  assign fast = is_fast(s_q.waveform_mode_select);
  assign pc = is_pc(s_q.waveform_mode_select);
  assign top_cap = s_q.waveform_mode_select == TFP_FAST_CAP || s_q.waveform_mode_select == TFP_PC_CAP;
  assign top_cmpa = s_q.waveform_mode_select == TFP_FAST_CMPA || s_q.waveform_mode_select == TFP_PC_CMPA;
  assign mask = res_mask(s_q.waveform_mode_select);
  // capture top unbuffered, compare a top uses the active copy
  assign top = top_cap ? s_q.capture_top_value : (top_cmpa ? s_q.compare_value[0] : mask);
  assign at_top = s_q.counter_value == top;
  assign wr = psel && penable && pwrite;

  always_comb begin
    s_d = s_q;
    ovf_set = 1'b0;
    cap_set = 1'b0;
    cmp_set = '0;
    match = '0;
    eff_up = 1'b0;
    clr = '0;
    // ********************
    // counting sequence
    // ********************
    if (timer_tick && (fast || pc)) begin
      if (fast) begin
        if (at_top) begin
          s_d.counter_value = TFP_BOTTOM;
          s_d.compare_value = s_q.cmp_buf;
          ovf_set = 1'b1;
          cap_set = top_cap;
          cmp_set[0] = top_cmpa;
        end else begin
          s_d.counter_value = s_q.counter_value + TFP_STEP; // a missed top wraps at full
        end
      end else if (!s_q.down) begin
        if (at_top) begin
          s_d.down = 1'b1; // top held one tick
          s_d.counter_value = s_q.counter_value - TFP_STEP;
          s_d.compare_value = s_q.cmp_buf;
          cap_set = top_cap;
          cmp_set[0] = top_cmpa;
        end else begin
          s_d.counter_value = s_q.counter_value + TFP_STEP;
        end
      end else if (s_q.counter_value == TFP_BOTTOM) begin
        s_d.down = 1'b0;
        s_d.counter_value = TFP_STEP;
      end else begin
        s_d.counter_value = s_q.counter_value - TFP_STEP;
        ovf_set = s_q.counter_value == TFP_STEP;
      end
      // ********************
      // compare outputs
      // ********************
      for (int i = 0; i < TFP_NCH; i++) begin
        match[i] = s_q.counter_value == s_q.compare_value[i];
        cmp_set[i] = cmp_set[i] | match[i];
        if (i == 0 && top_cmpa && s_q.compare_output_action[i] == TFP_ACT_TOGGLE) begin
          if (match[i]) begin
            s_d.compare_output[i] = !s_q.compare_output[i];
          end
        end else if (s_q.compare_output_action[i][1]) begin
          if (fast) begin
            // wrap wins over a match at top so compare top stays constant
            if (at_top) begin
              s_d.compare_output[i] = s_q.compare_output_action[i] == TFP_ACT_NONINV;
            end else if (match[i]) begin
              s_d.compare_output[i] = s_q.compare_output_action[i] == TFP_ACT_INV;
            end
          end else if (match[i]) begin
            // top counts as falling, bottom as rising: gives the flat extremes
            eff_up = at_top ? 1'b0 : (s_q.counter_value == TFP_BOTTOM ? 1'b1 : !s_q.down);
            s_d.compare_output[i] = (s_q.compare_output_action[i] == TFP_ACT_NONINV) ? !eff_up : eff_up;
          end
        end
      end
    end
    // ********************
    // register writes
    // ********************
    if (wr) begin
      if (paddr == TFP_OFF_CTRL) begin
        s_d.waveform_mode_select = pwdata[TFP_CTRL_MODE_LSB +: 4];
        s_d.compare_output_action = pwdata[TFP_CTRL_ACT_LSB +: 6];
        s_d.output_pin_direction = pwdata[TFP_CTRL_DIR_LSB +: 3];
      end else if (paddr == TFP_OFF_CMP_A || paddr == TFP_OFF_CMP_B || paddr == TFP_OFF_CMP_C) begin
        for (int i = 0; i < TFP_NCH; i++) begin
          if (paddr[3:2] == 2'(i + 1)) begin
            s_d.cmp_buf[i] = pwdata[15:0] & mask;
            if (!(fast || pc)) begin
              s_d.compare_value[i] = pwdata[15:0] & mask;
            end
          end
        end
      end else if (paddr == TFP_OFF_CAP_TOP) begin
        s_d.capture_top_value = pwdata[15:0];
      end else if (paddr == TFP_OFF_COUNT) begin
        s_d.counter_value = pwdata[15:0];
      end else if (paddr == TFP_OFF_FLAGS) begin
        clr = pwdata[4:0];
      end
    end
    // set beats a same-cycle clear
    s_d.overflow_flag = (s_q.overflow_flag && !clr[TFP_FLG_OVF]) || ovf_set;
    s_d.capture_match_flag = (s_q.capture_match_flag && !clr[TFP_FLG_CAP]) || cap_set;
    s_d.compare_match_flag = (s_q.compare_match_flag & ~clr[TFP_FLG_CMP_LSB +: 3]) | cmp_set;
    // ********************
    // read data, captured in the setup phase
    // ********************
    if (psel && !penable && !pwrite) begin
      s_d.rdata = '0;
      if (paddr == TFP_OFF_CTRL) begin
        s_d.rdata[TFP_CTRL_MODE_LSB +: 4] = s_q.waveform_mode_select;
        s_d.rdata[TFP_CTRL_ACT_LSB +: 6] = s_q.compare_output_action;
        s_d.rdata[TFP_CTRL_DIR_LSB +: 3] = s_q.output_pin_direction;
      end else if (paddr == TFP_OFF_CMP_A) begin
        s_d.rdata[15:0] = s_q.cmp_buf[0];
      end else if (paddr == TFP_OFF_CMP_B) begin
        s_d.rdata[15:0] = s_q.cmp_buf[1];
      end else if (paddr == TFP_OFF_CMP_C) begin
        s_d.rdata[15:0] = s_q.cmp_buf[2];
      end else if (paddr == TFP_OFF_CAP_TOP) begin
        s_d.rdata[15:0] = s_q.capture_top_value;
      end else if (paddr == TFP_OFF_COUNT) begin
        s_d.rdata[15:0] = s_q.counter_value;
      end else if (paddr == TFP_OFF_FLAGS) begin
        s_d.rdata[4:0] = {s_q.compare_match_flag, s_q.capture_match_flag, s_q.overflow_flag};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************
  // bus answer and pins
  // ********************
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == TFP_OFF_CTRL || paddr == TFP_OFF_CMP_A || paddr == TFP_OFF_CMP_B ||
      paddr == TFP_OFF_CMP_C || paddr == TFP_OFF_CAP_TOP || paddr == TFP_OFF_COUNT || paddr == TFP_OFF_FLAGS);

  always_comb begin
    for (int i = 0; i < TFP_NCH; i++) begin
      compare_pin_out[i] = (s_q.compare_output_action[i] != TFP_ACT_NONE) ? s_q.compare_output[i] : port_data[i];
      compare_pin_oe[i] = s_q.output_pin_direction[i];
    end
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fast_top_tick;
    timer_tick && fast && at_top && !wr;
  endsequence

  a_fast_wrap_clear: assert property (fast_top_tick |=> s_q.counter_value == TFP_BOTTOM && s_q.overflow_flag)
    else $error("fast pwm did not wrap with overflow");
  a_fast_buf_load: assert property (fast_top_tick |=> s_q.compare_value[0] == $past(s_q.cmp_buf[0]))
    else $error("compare a buffer not loaded at top");
  a_fast_top_flag: assert property ((fast_top_tick and top_cap) |=> s_q.capture_match_flag)
    else $error("capture flag missing at top");
  a_pc_top_turn: assert property (timer_tick && pc && !s_q.down && at_top && !wr
      |=> s_q.down && s_q.counter_value == $past(top) - TFP_STEP)
    else $error("phase correct did not turn at top");
  a_pc_bottom_ovf: assert property (timer_tick && pc && s_q.down && s_q.counter_value == TFP_STEP && !wr
      |=> s_q.counter_value == TFP_BOTTOM && s_q.overflow_flag)
    else $error("overflow missing at bottom");
  a_match_flag_b: assert property (timer_tick && (fast || pc) && s_q.counter_value == s_q.compare_value[1]
      |=> s_q.compare_match_flag[1])
    else $error("channel b match flag missing");
  a_no_tick_hold: assert property (!timer_tick && !wr |=> $stable(s_q.counter_value) && $stable(s_q.compare_output))
    else $error("counter moved without tick");
  a_fixed_mask_b: assert property (wr && paddr == TFP_OFF_CMP_B && s_q.waveform_mode_select == TFP_FAST_8
      |=> s_q.cmp_buf[1][15:8] == '0)
    else $error("compare bits above resolution kept");
  a_fast_match_clr: assert property (timer_tick && fast && !at_top && s_q.compare_output_action[1] == TFP_ACT_NONINV
      && s_q.counter_value == s_q.compare_value[1] |=> !s_q.compare_output[1])
    else $error("non-inverting output not cleared on match");
  a_pin_override: assert property (s_q.compare_output_action[2] != TFP_ACT_NONE
      |-> compare_pin_out[2] == s_q.compare_output[2])
    else $error("pin not driven by compare output");

  // ********************
  // counting, output, flag and register write checks
  // ********************
  sequence pc_top_tick;
    timer_tick && pc && !s_q.down && at_top && !wr;
  endsequence

  sequence pc_up_tick;
    timer_tick && pc && !s_q.down && !at_top && !wr;
  endsequence

  sequence pc_down_tick;
    timer_tick && pc && s_q.down && s_q.counter_value != TFP_BOTTOM && !wr;
  endsequence

  a_fast_count_up: assert property (timer_tick && fast && !at_top && !wr
      |=> s_q.counter_value == $past(s_q.counter_value) + TFP_STEP)
    else $error("fast pwm did not count up");
  a_fast_cmpa_flag: assert property ((fast_top_tick and top_cmpa)
      |=> s_q.compare_match_flag[0])
    else $error("compare a flag missing at top");
  a_fast_wrap_set: assert property ((fast_top_tick and s_q.compare_output_action[1] == TFP_ACT_NONINV)
      |=> s_q.compare_output[1])
    else $error("non-inverting output not set at wrap");
  a_fast_wrap_inv: assert property ((fast_top_tick and s_q.compare_output_action[1] == TFP_ACT_INV)
      |=> !s_q.compare_output[1])
    else $error("inverting output not cleared at wrap");
  a_fast_inv_match: assert property (timer_tick && fast && !at_top && s_q.compare_output_action[1] == TFP_ACT_INV
      && s_q.counter_value == s_q.compare_value[1] |=> s_q.compare_output[1])
    else $error("inverting output not set on match");
  a_pc_up_step: assert property (pc_up_tick
      |=> !s_q.down && s_q.counter_value == $past(s_q.counter_value) + TFP_STEP)
    else $error("phase correct did not count up");
  a_pc_down_step: assert property (pc_down_tick
      |=> s_q.down && s_q.counter_value == $past(s_q.counter_value) - TFP_STEP)
    else $error("phase correct did not count down");
  a_pc_bottom_turn: assert property (timer_tick && pc && s_q.down && s_q.counter_value == TFP_BOTTOM && !wr
      |=> !s_q.down && s_q.counter_value == TFP_STEP)
    else $error("phase correct did not turn at bottom");
  a_pc_buf_load: assert property (pc_top_tick
      |=> s_q.compare_value[1] == $past(s_q.cmp_buf[1]))
    else $error("phase correct buffer not loaded at top");
  a_pc_top_flag: assert property ((pc_top_tick and top_cap)
      |=> s_q.capture_match_flag)
    else $error("capture flag missing at phase correct top");
  a_pc_cmpa_flag: assert property ((pc_top_tick and top_cmpa)
      |=> s_q.compare_match_flag[0])
    else $error("compare a flag missing at phase correct top");
  a_pc_up_match: assert property ((pc_up_tick and s_q.counter_value != TFP_BOTTOM
      && s_q.compare_output_action[1] == TFP_ACT_NONINV && s_q.counter_value == s_q.compare_value[1]) |=> !s_q.compare_output[1])
    else $error("up match did not clear output");
  a_pc_down_match: assert property ((pc_down_tick and s_q.compare_output_action[1] == TFP_ACT_NONINV
      && s_q.counter_value == s_q.compare_value[1]) |=> s_q.compare_output[1])
    else $error("down match did not set output");
  a_pc_zero_low: assert property (timer_tick && pc && !at_top && s_q.counter_value == TFP_BOTTOM
      && s_q.compare_value[1] == TFP_BOTTOM && s_q.compare_output_action[1] == TFP_ACT_NONINV |=> !s_q.compare_output[1])
    else $error("compare zero did not hold output low");
  a_toggle_a_flip: assert property (timer_tick && top_cmpa && s_q.compare_output_action[0] == TFP_ACT_TOGGLE
      && s_q.counter_value == s_q.compare_value[0] |=> s_q.compare_output[0] != $past(s_q.compare_output[0]))
    else $error("channel a did not toggle on match");
  a_toggle_b_none: assert property (timer_tick && s_q.compare_output_action[1] == TFP_ACT_TOGGLE
      |=> $stable(s_q.compare_output[1]))
    else $error("toggle applied outside channel a");
  a_none_out_hold: assert property (s_q.compare_output_action[2] == TFP_ACT_NONE
      |=> $stable(s_q.compare_output[2]))
    else $error("output changed with action zero");
  a_match_flag_c: assert property (timer_tick && (fast || pc) && s_q.counter_value == s_q.compare_value[2]
      |=> s_q.compare_match_flag[2])
    else $error("channel c match flag missing");
  a_stopped_hold: assert property (timer_tick && !(fast || pc) && !wr
      |=> $stable(s_q.counter_value))
    else $error("counter moved outside pwm modes");
  a_pin_oe_dir: assert property (compare_pin_oe == s_q.output_pin_direction
      )
    else $error("pin enable differs from direction bits");
  a_pin_port_pass: assert property (s_q.compare_output_action[0] == TFP_ACT_NONE
      |-> compare_pin_out[0] == port_data[0])
    else $error("port value not passed with action zero");
  a_reset_out_zero: assert property (disable iff (1'b0) !presetn
      |-> s_q.compare_output == '0)
    else $error("compare output not cleared in reset");
  a_cmp_mask_c: assert property (wr && paddr == TFP_OFF_CMP_C && s_q.waveform_mode_select == TFP_PC_10
      |=> s_q.cmp_buf[2][15:10] == '0)
    else $error("compare c bits above resolution kept");
  a_cap_unbuf: assert property (wr && paddr == TFP_OFF_CAP_TOP
      |=> s_q.capture_top_value == $past(pwdata[15:0]))
    else $error("capture top not taken at once");
  a_cmpa_buffered: assert property (wr && paddr == TFP_OFF_CMP_A && (fast || pc) && !timer_tick
      |=> $stable(s_q.compare_value[0]))
    else $error("compare a write bypassed the buffer");

endmodule // tfp_timer

/* rtl/tfp_pkg.sv */
// constants for the 16-bit fast / phase correct pwm timer block
// assumes an apb master on pclk and a prescaler strobe in the same domain
package tfp_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [7:0] TFP_OFF_CTRL = 8'h00;
  localparam logic [7:0] TFP_OFF_CMP_A = 8'h04;
  localparam logic [7:0] TFP_OFF_CMP_B = 8'h08;
  localparam logic [7:0] TFP_OFF_CMP_C = 8'h0C;
  localparam logic [7:0] TFP_OFF_CAP_TOP = 8'h10;
  localparam logic [7:0] TFP_OFF_COUNT = 8'h14;
  localparam logic [7:0] TFP_OFF_FLAGS = 8'h18;

  // ********************
  // control and flag fields
  // ********************
  localparam int TFP_CTRL_MODE_LSB = 0;
  localparam int TFP_CTRL_ACT_LSB = 4;
  localparam int TFP_CTRL_DIR_LSB = 10;
  localparam int TFP_FLG_OVF = 0;
  localparam int TFP_FLG_CAP = 1;
  localparam int TFP_FLG_CMP_LSB = 2;
  localparam int TFP_NCH = 3;

  // ********************
  // waveform mode codes
  // ********************
  localparam logic [3:0] TFP_PC_8 = 4'h1;
  localparam logic [3:0] TFP_PC_9 = 4'h2;
  localparam logic [3:0] TFP_PC_10 = 4'h3;
  localparam logic [3:0] TFP_FAST_8 = 4'h5;
  localparam logic [3:0] TFP_FAST_9 = 4'h6;
  localparam logic [3:0] TFP_FAST_10 = 4'h7;
  localparam logic [3:0] TFP_PC_CAP = 4'hA;
  localparam logic [3:0] TFP_PC_CMPA = 4'hB;
  localparam logic [3:0] TFP_FAST_CAP = 4'hE;
  localparam logic [3:0] TFP_FAST_CMPA = 4'hF;

  // ********************
  // output action codes and counter values
  // ********************
  localparam logic [1:0] TFP_ACT_NONE = 2'h0;
  localparam logic [1:0] TFP_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TFP_ACT_NONINV = 2'h2;
  localparam logic [1:0] TFP_ACT_INV = 2'h3;
  localparam logic [15:0] TFP_TOP_8 = 16'h00FF;
  localparam logic [15:0] TFP_TOP_9 = 16'h01FF;
  localparam logic [15:0] TFP_TOP_10 = 16'h03FF;
  localparam logic [15:0] TFP_FULL = 16'hFFFF;
  localparam logic [15:0] TFP_BOTTOM = 16'h0000;
  localparam logic [15:0] TFP_STEP = 16'h0001;
endpackage : tfp_pkg

/* dv/tfp_pin_load.sv */
// far-side load on the three compare pins: a weak pull-down on each line
// assumes compare_pin_oe is high while the timer drives the pin
module tfp_pin_load (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin settles low, never at the last driven value
  assign pin_level = pin_oe & pin_out;
endmodule // tfp_pin_load

/* dv/testbench.sv */
// self-checking bench for tfp_timer: apb driver, random tick stream, cycle model of the pwm unit
// assumes zero-wait apb, one pclk per tick strobe, and the pin load model on the compare pins
module testbench
  import tfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_tick, m_up;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] port_data, pin_out, pin_oe, pin_lvl, m_dir, m_oc;
  logic [2:0][1:0] m_ac;
  logic [15:0] m_cnt, m_buf, m_act, m_cap;
  logic [4:0] m_flg;
  logic [3:0] m_mode;
  logic [32:0] exp_q[$];
  // mode, action a, capture top, first compare, second compare
  // top kept at 0x0003 or more compares at or below top top static while counting
  logic [55:0] sc[14] = '{56'h5_2_0000_FF80_FFC0, 56'h6_3_0000_FE10_0100, 56'h7_2_0000_FC05_0000,
    56'hE_3_0009_0003_0009, 56'hE_2_0006_0000_0006, 56'hE_0_0008_0004_0002, 56'hF_1_0000_0004_0007,
    56'hF_2_0000_0005_0003, 56'h1_2_0000_FF20_00FF, 56'h2_3_0000_FE40_0000, 56'h3_2_0000_FC00_0010,
    56'hA_2_0007_0003_0000, 56'hA_3_0007_0007_0002, 56'hB_1_0000_0005_0009};
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  tfp_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .port_data(port_data), .compare_pin_out(pin_out), .compare_pin_oe(pin_oe));
  tfp_pin_load load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_lvl));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ********************
  // reference model, stepped once per tick
  // ********************
  function automatic logic fixed();
    return m_mode[3] == 1'b0 && m_mode[1:0] != 2'h0;
  endfunction

  function automatic logic [15:0] top_of();
    if (fixed()) return {6'h00, m_mode[1:0] == 2'h3, m_mode[1:0] != 2'h1, 8'hFF};
    return (m_mode[0]) ? m_act : m_cap;
  endfunction

  function automatic logic [2:0] exp_out();
    logic [2:0] v;
    for (int i = 0; i < 3; i++) v[i] = (m_ac[i] != TFP_ACT_NONE) ? m_oc[i] : port_data[i];
    return v;
  endfunction

  // e high: set-type event for non-inverting outputs
  task automatic fire(input logic e);
    for (int i = 0; i < 3; i++) begin
      if (m_ac[i] == TFP_ACT_NONINV) m_oc[i] = e;
      if (m_ac[i] == TFP_ACT_INV) m_oc[i] = ~e;
      if (m_ac[i] == TFP_ACT_TOGGLE && i == 0 && m_mode[3] && m_mode[1:0] == 2'h3) m_oc[i] = ~m_oc[i];
    end
  endtask

  task automatic step();
    logic [15:0] c, t, a;
    c = m_cnt;
    t = top_of();
    a = m_act;
    if (c == a) m_flg[4:2] = 3'h7;
    if (m_mode[2] || c == t && m_up) begin
      m_act = (c == t) ? m_buf : m_act;
      m_flg[1] = m_flg[1] | (c == t && m_mode[3] && !m_mode[0]);
    end
    if (m_mode[2] && c == t) begin
      m_cnt = TFP_BOTTOM;
      m_flg[0] = 1'b1;
      fire(1'b1);
    end else if (m_mode[2] || m_up && c != t) begin
      if (c == a) fire(1'b0);
      m_cnt = c + TFP_STEP;
    end else if (m_up) begin
      m_up = 1'b0;
      m_cnt = t - TFP_STEP;
      if (c == a) fire(1'b1);
    end else if (c == TFP_BOTTOM) begin
      m_up = 1'b1;
      m_cnt = TFP_STEP;
      if (c == a) fire(1'b0);
    end else begin
      if (c == a) fire(1'b1);
      m_flg[0] = m_flg[0] | (c == TFP_STEP);
      m_cnt = c - TFP_STEP;
    end
  endtask

  // ********************
  // bus and tick drivers
  // ********************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    timer_tick <= 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    if (w) begin
      case (a)
        TFP_OFF_CTRL: {m_dir, m_ac, m_mode} = d[12:0];
        TFP_OFF_CMP_A: m_buf = d[15:0] & (fixed() ? top_of() : TFP_FULL);
        TFP_OFF_CAP_TOP: m_cap = d[15:0];
        TFP_OFF_COUNT: m_cnt = d[15:0];
        TFP_OFF_FLAGS: m_flg = m_flg & ~d[4:0];
        default: ;
      endcase
      if (m_mode == 4'h0) m_act = m_buf;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic err = 1'b0);
    exp_q.push_back({err, 16'h0000, e});
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic cmp3(input logic [15:0] v);
    for (int i = 0; i < 3; i++) bus(1'b1, TFP_OFF_CMP_A + 8'(4 * i), {16'h0000, v});
  endtask

  task automatic run(input int n);
    logic t;
    for (int k = 0; k < n; k++) begin
      t = 1'($urandom_range(0, 1));
      timer_tick <= t;
      @(posedge pclk);
      if (t) step();
    end
  endtask

  task automatic rst();
    presetn <= 1'b0;
    {m_cnt, m_buf, m_act, m_cap, m_flg, m_mode, m_dir, m_oc, m_ac} = '0;
    m_up = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ********************
  // monitors and main sequence
  // ********************
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      give_verdict();
    end
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) cmp({pslverr, prdata}, exp_q.pop_front());
  end

  always @(negedge pclk) begin
    cmp({27'h0, pin_oe, pin_out}, {27'h0, m_dir, exp_out()});
    cmp({30'h0, pin_lvl}, {30'h0, m_dir & exp_out()});
  end

  initial begin
    {psel, penable, pwrite, timer_tick, paddr, pwdata, port_data} = '0;
    void'($urandom(32'hEDD6E4B0));
    rst();
    rd(TFP_OFF_COUNT, 16'h0000);
    bus(1'b1, 8'h1C, 32'h0000FFFF);
    rd(8'h1C, 16'h0000, 1'b1);
    foreach (sc[s]) begin
      rst();
      port_data <= 3'($urandom);
      cmp3(sc[s][31:16]);
      bus(1'b1, TFP_OFF_CAP_TOP, {16'h0000, sc[s][47:32]});
      bus(1'b1, TFP_OFF_CTRL, {19'h0, 3'($urandom), 1'b1, 1'($urandom), 2'($urandom), sc[s][49:48], sc[s][55:52]});
      cmp3(sc[s][31:16]);
      rd(TFP_OFF_CMP_A, m_buf);
      run(fixed() ? 700 : 60);
      cmp3(sc[s][15:0]);
      rd(TFP_OFF_CMP_B, m_buf);
      run(fixed() ? 700 : 60);
      rd(TFP_OFF_COUNT, m_cnt);
      rd(TFP_OFF_FLAGS, {11'h000, m_flg});
      bus(1'b1, TFP_OFF_FLAGS, 32'h0000001F);
      rd(TFP_OFF_FLAGS, 16'h0000);
    end
    rst();
    bus(1'b1, TFP_OFF_CAP_TOP, 32'h00000009);
    bus(1'b1, TFP_OFF_CTRL, 32'h00001CAE);
    bus(1'b1, TFP_OFF_COUNT, 32'h0000FFF0);
    run(40);
    rd(TFP_OFF_COUNT, m_cnt);
    give_verdict();
  end
endmodule // testbench
